// ### rtl/asse_map.svh
// Purpose: Register map, field positions and timing counts for the axis status block
// Assumes: 20 MHz pclk
// Notes:   Included by the top module and the bench
//
// Behaviour
// - Green lamp steady on when axis initialized, reference valid, not moving.
// - Green lamp dark while axis not initialized.
// - Green lamp blinks 1 Hz when initialized, reference invalid, stationary.
// - Green lamp blinks 2 Hz while initialized and moving; overrides steady and slow patterns.
// - Red lamp steady on while no axis error is recorded.
// - Red lamp blinks 1 Hz while any axis error is recorded.
// - Limit, brake, stage fault or time-out each count as axis error.
// - Fitted stage enable jumper permits stage activation regardless of release input.
// - Without jumper, activation only while external release (5 V) is asserted.
// - Neither jumper nor release: stages stay inactive, requests refused.
// - Stage runs only with the motor type it was preconfigured for.
// - Coding short means DC servo, open means two-phase stepper.
// - Coding sampled once after reset; mismatch raises readable stage error.
`ifndef ASSE_MAP_SVH
`define ASSE_MAP_SVH

`define ASSE_CLK_HZ         20000000
`define ASSE_SLOW_HZ        1
`define ASSE_FAST_HZ        2
// Half period counts for a 50 percent square wave
`define ASSE_SLOW_HALF      (`ASSE_CLK_HZ / (2 * `ASSE_SLOW_HZ))
`define ASSE_FAST_HALF      (`ASSE_CLK_HZ / (2 * `ASSE_FAST_HZ))

`define ASSE_OFF_CTRL       12'h000
`define ASSE_OFF_STAT       12'h004
`define ASSE_OFF_IRQ_STAT   12'h008
`define ASSE_OFF_IRQ_MASK   12'h00c
`define ASSE_OFF_SLOW_DIV   12'h010
`define ASSE_OFF_FAST_DIV   12'h014

// Control register fields
`define ASSE_CTRL_INIT      0
`define ASSE_CTRL_REF       1
`define ASSE_CTRL_MOVE      2
`define ASSE_CTRL_REQ       3
`define ASSE_CTRL_TYPE      4
`define ASSE_CTRL_TOUT      5

// Status / interrupt fields
`define ASSE_ST_ERR         0
`define ASSE_ST_STAGE_ERR   1
`define ASSE_ST_ALLOW       2
`define ASSE_ST_ACTIVE      3
`define ASSE_ST_TYPE        4
`define ASSE_ST_REFUSED     5
`define ASSE_IRQ_W          4
`define ASSE_IRQ_ERR        0
`define ASSE_IRQ_STAGE      1
`define ASSE_IRQ_REFUSE     2
`define ASSE_IRQ_ALLOW_LOST 3

`define ASSE_CTRL_RST       32'h0000_0000
`define ASSE_ZERO           32'h0000_0000

`endif

// ### rtl/asse_pkg.sv
// Purpose: Types for the axis status and stage enable block
// Assumes: Constants come from asse_map.svh
// Notes:   Motor types and the fault input group
package asse_pkg;

  // Motor type: 0 DC servo (coding short), 1 stepper (coding open)
  typedef enum logic
  {
    ASSE_MOTOR_DC   = 1'b0,
    ASSE_MOTOR_STEP = 1'b1
  } asse_motor_e;

  typedef enum logic [1:0]
  {
    ASSE_IDLE   = 2'b00,
    ASSE_SAMPLE = 2'b01,
    ASSE_RUN    = 2'b11
  } asse_state_e;

  typedef struct packed
  {
    logic limit_hit;
    logic brake_event;
    logic stage_fault;
  } asse_fault_s;

endpackage

// ### rtl/asse_top.sv
// Purpose: Axis status lamps and motor stage interlock with an APB register slave
// Assumes: All inputs synchronous to pclk; presetn asynchronous, active low
// Notes:   Registers: control, status, sticky irq status (clear on read), mask, dividers
`timescale 1ns/100ps
`default_nettype none
`include "asse_map.svh"

module asse_top
  import asse_pkg::*;
#(
  parameter logic [31:0] SLOW_HALF_DEF = 32'(`ASSE_SLOW_HALF),
  parameter logic [31:0] FAST_HALF_DEF = 32'(`ASSE_FAST_HALF),
  parameter asse_motor_e STAGE_TYPE    = ASSE_MOTOR_STEP
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire asse_fault_s fault_in,
  input  wire logic        stage_enable_jumper,
  input  wire logic        ext_release,
  input  wire logic        motor_code_open,
  output logic             green_lamp,
  output logic             red_lamp,
  output logic             stage_active,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0]            ctrl;
  logic [31:0]            next_ctrl;
  logic [31:0]            slow_half;
  logic [31:0]            next_slow_half;
  logic [31:0]            fast_half;
  logic [31:0]            next_fast_half;
  logic [`ASSE_IRQ_W-1:0] irq_stat;
  logic [`ASSE_IRQ_W-1:0] next_irq_stat;
  logic [`ASSE_IRQ_W-1:0] irq_mask;
  logic [`ASSE_IRQ_W-1:0] next_irq_mask;
  logic [31:0]            next_prdata;
  logic [31:0]            stat_word;

  // ----------------------------------------------------------------
  // Motor coding and interlock
  // ----------------------------------------------------------------
  asse_state_e state;
  asse_state_e next_state;
  asse_motor_e motor_type;
  asse_motor_e next_motor_type;
  logic        stage_err;
  logic        next_stage_err;
  logic        allow;
  logic        allow_d;
  logic        axis_err;
  logic        req;
  logic        refused;
  logic        next_active;

  // ----------------------------------------------------------------
  // Blink dividers
  // ----------------------------------------------------------------
  logic [31:0] slow_cnt;
  logic [31:0] next_slow_cnt;
  logic [31:0] fast_cnt;
  logic [31:0] next_fast_cnt;
  logic        slow_wave;
  logic        next_slow_wave;
  logic        fast_wave;
  logic        next_fast_wave;
  logic        next_green;
  logic        next_red;

  function automatic logic [31:0] div_step(input logic [31:0] cnt, input logic [31:0] half);
    if (cnt + 32'h0000_0001 >= half)
    begin
      return `ASSE_ZERO;
    end
    return cnt + 32'h0000_0001;
  endfunction

  // Coding decode: short is DC servo, open is stepper
  always_comb
  begin
    next_state      = state;
    next_motor_type = motor_type;
    next_stage_err  = stage_err;
    case (state)
      ASSE_IDLE:
      begin
        next_state = ASSE_SAMPLE;
      end
      ASSE_SAMPLE:
      begin
        next_motor_type = motor_code_open ? ASSE_MOTOR_STEP : ASSE_MOTOR_DC;
        next_stage_err  = (motor_code_open ? ASSE_MOTOR_STEP : ASSE_MOTOR_DC)
                          != STAGE_TYPE;
        next_state      = ASSE_RUN;
      end
      default:
      begin
        next_state = ASSE_RUN;
      end
    endcase
  end

  assign allow    = stage_enable_jumper | ext_release;
  assign axis_err = fault_in.limit_hit | fault_in.brake_event | fault_in.stage_fault
                    | stage_err | ctrl[`ASSE_CTRL_TOUT];
  assign req      = ctrl[`ASSE_CTRL_REQ];
  // Stage off until coding checked and matched
  assign next_active = req & allow & (state == ASSE_RUN) & ~stage_err;
  assign refused     = req & ~next_active;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= ASSE_IDLE;
      motor_type   <= ASSE_MOTOR_DC;
      stage_err    <= 1'b0;
      stage_active <= 1'b0;
      allow_d      <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      motor_type   <= next_motor_type;
      stage_err    <= next_stage_err;
      stage_active <= next_active;
      allow_d      <= allow;
    end
  end

  // ----------------------------------------------------------------
  // Blink waves and lamp patterns
  // ----------------------------------------------------------------
  // Phase restarts at reset; a shorter new half period wraps at once
  always_comb
  begin
    next_slow_cnt  = div_step(slow_cnt, slow_half);
    next_fast_cnt  = div_step(fast_cnt, fast_half);
    next_slow_wave = (next_slow_cnt == `ASSE_ZERO) ? ~slow_wave : slow_wave;
    next_fast_wave = (next_fast_cnt == `ASSE_ZERO) ? ~fast_wave : fast_wave;
    if (!ctrl[`ASSE_CTRL_INIT])
    begin
      next_green = 1'b0;
    end
    else if (ctrl[`ASSE_CTRL_MOVE])
    begin
      next_green = fast_wave;
    end
    else if (ctrl[`ASSE_CTRL_REF])
    begin
      next_green = 1'b1;
    end
    else
    begin
      next_green = slow_wave;
    end
    next_red = axis_err ? slow_wave : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_cnt   <= `ASSE_ZERO;
      fast_cnt   <= `ASSE_ZERO;
      slow_wave  <= 1'b1;
      fast_wave  <= 1'b1;
      green_lamp <= 1'b0;
      red_lamp   <= 1'b0;
    end
    else
    begin
      slow_cnt   <= next_slow_cnt;
      fast_cnt   <= next_fast_cnt;
      slow_wave  <= next_slow_wave;
      fast_wave  <= next_fast_wave;
      green_lamp <= next_green;
      red_lamp   <= next_red;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic [`ASSE_IRQ_W-1:0] events;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  // Read data captured at the setup edge so it stands through the access phase
  assign rd      = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign stat_word = {26'h000_0000, refused, motor_type, stage_active, allow,
                      stage_err, axis_err};
  assign events = {allow_d & ~allow, refused, stage_err, axis_err};
  assign irq    = |(irq_stat & irq_mask);

  always_comb
  begin
    next_ctrl      = ctrl;
    next_slow_half = slow_half;
    next_fast_half = fast_half;
    next_irq_mask  = irq_mask;
    next_irq_stat  = irq_stat;
    next_prdata    = prdata;
    if (wr)
    begin
      if (paddr == `ASSE_OFF_CTRL)
      begin
        next_ctrl = pwdata;
      end
      else if (paddr == `ASSE_OFF_IRQ_MASK)
      begin
        next_irq_mask = pwdata[`ASSE_IRQ_W-1:0];
      end
      else if (paddr == `ASSE_OFF_SLOW_DIV)
      begin
        next_slow_half = pwdata;
      end
      else if (paddr == `ASSE_OFF_FAST_DIV)
      begin
        next_fast_half = pwdata;
      end
    end
    if (rd)
    begin
      if (paddr == `ASSE_OFF_CTRL)
      begin
        next_prdata = ctrl;
      end
      else if (paddr == `ASSE_OFF_STAT)
      begin
        next_prdata = stat_word;
      end
      else if (paddr == `ASSE_OFF_IRQ_STAT)
      begin
        // Clear comes with the capture, so an event in this cycle is kept
        next_prdata   = {28'h000_0000, irq_stat};
        next_irq_stat = '0;
      end
      else if (paddr == `ASSE_OFF_IRQ_MASK)
      begin
        next_prdata = {28'h000_0000, irq_mask};
      end
      else if (paddr == `ASSE_OFF_SLOW_DIV)
      begin
        next_prdata = slow_half;
      end
      else if (paddr == `ASSE_OFF_FAST_DIV)
      begin
        next_prdata = fast_half;
      end
      else
      begin
        next_prdata = `ASSE_ZERO;
      end
    end
    // Set wins over read clear
    next_irq_stat = next_irq_stat | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl      <= `ASSE_CTRL_RST;
      slow_half <= SLOW_HALF_DEF;
      fast_half <= FAST_HALF_DEF;
      irq_stat  <= '0;
      irq_mask  <= '0;
      prdata    <= `ASSE_ZERO;
    end
    else
    begin
      ctrl      <= next_ctrl;
      slow_half <= next_slow_half;
      fast_half <= next_fast_half;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      prdata    <= next_prdata;
    end
  end

endmodule

`default_nettype wire

// ### testbench/asse_panel_model.sv
// Purpose: Front panel lamps seen by an observer
// Assumes: Lamps sampled each rising pclk edge
// Notes:   Reports the last full on or off run of each lamp
`timescale 1ns/100ps
`default_nettype none
module asse_panel_model
(
  input  wire logic       pclk,
  input  wire logic       green_lamp,
  input  wire logic       red_lamp,
  output logic      [7:0] green_half,
  output logic      [7:0] red_half
);
  logic       g_d = 1'b0;
  logic       r_d = 1'b0;
  logic [7:0] g_cnt = 8'h00;
  logic [7:0] r_cnt = 8'h00;
  always @(posedge pclk)
  begin
    g_d <= green_lamp;
    r_d <= red_lamp;
    g_cnt <= (green_lamp != g_d) ? 8'h01 : g_cnt + 8'h01;
    r_cnt <= (red_lamp != r_d) ? 8'h01 : r_cnt + 8'h01;
    if (green_lamp != g_d)
      green_half <= g_cnt;
    if (red_lamp != r_d)
      red_half <= r_cnt;
  end
endmodule
`default_nettype wire

// ### testbench/asse_props.sv
// Purpose: Port checks for asse_top
// Assumes: Sim half periods of 20 and 10 cycles
// Notes:   Bound to asse_top below
`timescale 1ns/100ps
`default_nettype none
module asse_props
  import asse_pkg::*;
#(
  parameter logic [31:0] SLOW_HALF_DEF = 32'h0000_0014
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire asse_fault_s fault_in,
  input wire logic        stage_enable_jumper,
  input wire logic        ext_release,
  input wire logic        red_lamp,
  input wire logic        stage_active
);
  localparam int RED_WAIT = 24;
  logic [31:0] low_run;
  logic [31:0] next_low_run;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of the current dark run of the red lamp
  always_comb next_low_run = red_lamp ? 32'h0000_0000 : low_run + 32'h0000_0001;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      low_run <= 32'h0000_0000;
    else
      low_run <= next_low_run;
  a_stage_blocked: assert property (!stage_enable_jumper && !ext_release |=> !stage_active)
    else $error("stage active without any enable");
  a_stage_cause: assert property (stage_active |-> $past(stage_enable_jumper || ext_release))
    else $error("stage active without enable one cycle before");
  a_ready_high: assert property (psel && penable |-> pready && !pslverr)
    else $error("access not answered at once");
  a_unmapped_zero: assert property (psel && penable && !pwrite && paddr >= 12'h018
    |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_red_low_len: assert property (!red_lamp |-> low_run <= SLOW_HALF_DEF)
    else $error("red dark longer than half period");
  a_red_on_fault: assert property (fault_in != '0 |-> ##[0:RED_WAIT] (!red_lamp || fault_in == '0))
    else $error("red lamp not blinking on fault");
  a_red_min_low: assert property ($fell(red_lamp) && fault_in != '0 ##1 (fault_in != '0)[*6]
    |-> !red_lamp)
    else $error("red dark phase too short");
endmodule
bind asse_top asse_props #(.SLOW_HALF_DEF(SLOW_HALF_DEF)) u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .fault_in, .stage_enable_jumper,
  .ext_release, .red_lamp, .stage_active);
`default_nettype wire

// ### testbench/asse_top_bench.sv
// Purpose: Self-checking bench for asse_top
// Assumes: Half periods shortened to 20 and 10 cycles
// Notes:   Stage type stepper, open coding matches
`timescale 1ns/100ps
`default_nettype none
`include "asse_map.svh"
module asse_top_bench import asse_pkg::*;;
  localparam logic [31:0] SLOW = 32'h0000_0014;
  localparam logic [31:0] FAST = 32'h0000_000a;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        green_lamp;
  logic        red_lamp;
  logic        stage_active;
  logic        irq;
  asse_fault_s fault_in = '0;
  logic        stage_enable_jumper = 1'b0;
  logic        ext_release = 1'b0;
  logic        motor_code_open = 1'b1;
  logic [7:0]  green_half;
  logic [7:0]  red_half;
  int          bad_count = 0;
  int          checked = 0;
  always #25 pclk = ~pclk;
  asse_top #(.SLOW_HALF_DEF(SLOW), .FAST_HALF_DEF(FAST)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in, .stage_enable_jumper,
    .ext_release, .motor_code_open, .green_lamp, .red_lamp, .stage_active, .irq);
  asse_panel_model u_panel (.pclk, .green_lamp, .red_lamp, .green_half, .red_half);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge pclk);
  endtask
  // One APB transfer; read data taken at the access edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drive(input asse_fault_s f, input logic j, input logic r);
    @(posedge pclk);
    fault_in <= f;
    stage_enable_jumper <= j;
    ext_release <= r;
  endtask
  task automatic do_reset(input logic code);
    @(posedge pclk);
    presetn <= 1'b0;
    motor_code_open <= code;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    idle(3);
    chk(32'(green_lamp), 32'h0000_0000);
    chk(32'(stage_active), 32'h0000_0000);
    $display("reset done");
  endtask
  task automatic t_green;
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0003);
    idle(25);
    chk(32'(green_lamp), 32'h0000_0001);
    idle(25);
    chk(32'(green_lamp), 32'h0000_0001);
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0001);
    idle(60);
    chk(32'(green_half), SLOW);
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0007);
    idle(40);
    chk(32'(green_half), FAST);
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0004);
    idle(25);
    chk(32'(green_lamp), 32'h0000_0000);
    $display("green test done");
  endtask
  task automatic t_red;
    apb(1'b1, `ASSE_OFF_IRQ_MASK, 32'h0000_000f);
    for (int i = 0; i < 4; i++)
    begin
      chk(32'(red_lamp), 32'h0000_0001);
      if (i < 3)
        drive(asse_fault_s'(3'b001 << i), 1'b0, 1'b0);
      else
        apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0020);
      idle(60);
      chk(32'(red_half), SLOW);
      chk(32'(irq), 32'h0000_0001);
      drive('0, 1'b0, 1'b0);
      apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0000);
      apb(1'b0, `ASSE_OFF_IRQ_STAT, 32'h0000_0000);
      chk(32'(rd[0]), 32'h0000_0001);
      apb(1'b0, `ASSE_OFF_IRQ_STAT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      idle(3);
      chk(32'(irq), 32'h0000_0000);
    end
    apb(1'b1, `ASSE_OFF_IRQ_MASK, 32'h0000_0000);
    drive('1, 1'b0, 1'b0);
    idle(5);
    chk(32'(irq), 32'h0000_0000);
    drive('0, 1'b0, 1'b0);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("red test done");
  endtask
  task automatic t_stage;
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0009);
    for (int k = 3; k >= 0; k--)
    begin
      drive('0, k[1], k[0]);
      idle(3);
      chk(32'(stage_active), 32'(k[1] | k[0]));
      apb(1'b0, `ASSE_OFF_STAT, 32'h0000_0000);
      chk(32'(rd[2]), 32'(k[1] | k[0]));
      chk(32'(rd[4]), 32'h0000_0001);
      chk(32'(rd[5]), 32'(!(k[1] | k[0])));
    end
    $display("stage test done");
  endtask
  task automatic t_motor;
    drive('0, 1'b1, 1'b1);
    do_reset(1'b0);
    apb(1'b1, `ASSE_OFF_CTRL, 32'h0000_0009);
    idle(60);
    chk(32'(stage_active), 32'h0000_0000);
    chk(32'(red_half), SLOW);
    apb(1'b0, `ASSE_OFF_STAT, 32'h0000_0000);
    chk(32'(rd[1]), 32'h0000_0001);
    chk(32'(rd[4]), 32'h0000_0000);
    $display("motor test done");
  endtask
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    do_reset(1'b1);
    t_green;
    t_red;
    t_stage;
    t_motor;
    wrap_up;
  end
endmodule
`default_nettype wire
